// ===== shared/shift_unit_pkg.sv
// Package for the microcore shift unit: opcode prefixes, field positions, widths.
// Assumes a 16-bit instruction word and a 16-bit ALU register file.
package shift_unit_pkg;
   localparam int DATA_WIDTH  = 16;
   localparam int WIDE_WIDTH  = 32;
   localparam int SEL_WIDTH   = 3;
   localparam int CNT_WIDTH   = 16;
   localparam int BYTE_SHIFT  = 8;
   // Opcode prefixes, compared against the upper instruction bits; OP_PROD_TAIL against the low three bits.
   localparam logic [9:0]  OP_PROD_RIGHT_REG  = 10'h0E4;  // 0011100100
   localparam logic [8:0]  OP_PROD_RIGHT_IMM  = 9'h070;   // 001110000
   localparam logic [2:0]  OP_PROD_TAIL       = 3'h5;     // 101
   localparam logic [9:0]  OP_LEFT_REG        = 10'h0BA;  // 0010111010
   localparam logic [9:0]  OP_LEFT_SIGNED_REG = 10'h0B8;  // 0010111000
   localparam logic [9:0]  OP_RIGHT_REG       = 10'h0B9;  // 0010111001
   localparam logic [9:0]  OP_RIGHT_SIGNED_REG= 10'h0B7;  // 0010110111
   localparam logic [8:0]  OP_LEFT_IMM        = 9'h05A;   // 001011010
   localparam logic [8:0]  OP_LEFT_SIGNED_IMM = 9'h058;   // 001011000
   localparam logic [8:0]  OP_RIGHT_IMM       = 9'h059;   // 001011001
   localparam logic [12:0] OP_LEFT_BYTE       = 13'h05DF; // 0010111011111
   localparam logic [12:0] OP_RIGHT_BYTE      = 13'h05DE; // 0010111011110
   // Field positions inside the instruction word.
   localparam int IMM_LSB    = 3;
   localparam int AMT_LSB    = 3;
   localparam int TGT_LSB    = 0;
   // Reset values.
   localparam logic [DATA_WIDTH-1:0] RESET_DATA = 16'h0000;
   localparam logic [CNT_WIDTH-1:0]  RESET_CNT  = 16'h0000;
   // Kind of shift being run.
   typedef enum logic [2:0] {
      K_NONE, K_PROD_RIGHT, K_LEFT, K_LEFT_SIGNED, K_RIGHT, K_RIGHT_SIGNED
   } shift_kind_t;
endpackage : shift_unit_pkg

// ===== logic/microcore_shift_unit.sv
// Shift unit of a microcore ALU: decodes shift instructions and runs them.
// Assumes the sequencer holds i_instr_valid for one cycle per instruction and
// waits for o_done before issuing the next one; operand values come from the
// register file on the same clock, selected by o_amount_sel and o_target_sel.
// Summary of operation
// RULE_01: Product pair is high half over low half.
// RULE_02: Product right shift by register, cycle per bit.
// RULE_03: Product right shift by immediate, cycle per bit.
// RULE_04: Right shifts update shift-out and precision-loss flags.
// RULE_05: Left shifts update shift-out and overflow flags.
// RULE_06: Left shift by register, cycle per bit.
// RULE_07: Right shift by register, cycle per bit.
// RULE_08: Byte shifts move eight bits in one cycle.
// RULE_09: Immediate shifts take cycles equal to amount.
// RULE_10: Signed shifts keep the sign bit.
// RULE_11: Register operands are 3-bit ALU set selects.
// RULE_12: Decode product right shift register and immediate forms.
// RULE_13: Decode the four register-amount shift prefixes.
// RULE_14: Decode the three immediate shift prefixes.
// RULE_15: Decode the two byte shift prefixes.
// RULE_16: Zero fill, signed right fills with sign.
`timescale 1ns/1ps
module microcore_shift_unit (
   input  wire logic                                i_clock,
   input  wire logic                                i_reset_n,
   input  wire logic                                i_instr_valid,
   input  wire logic [15:0]                         i_instr,
   input  wire logic [shift_unit_pkg::DATA_WIDTH-1:0] i_amount_value,
   input  wire logic [shift_unit_pkg::DATA_WIDTH-1:0] i_target_value,
   input  wire logic [shift_unit_pkg::DATA_WIDTH-1:0] i_product_high_half,
   input  wire logic [shift_unit_pkg::DATA_WIDTH-1:0] i_product_low_half,
   output logic [shift_unit_pkg::SEL_WIDTH-1:0]     o_amount_sel,
   output logic [shift_unit_pkg::SEL_WIDTH-1:0]     o_target_sel,
   output logic                                     o_busy,
   output logic                                     o_done,
   output logic                                     o_write_alu,
   output logic                                     o_write_product,
   output logic [shift_unit_pkg::DATA_WIDTH-1:0]    o_result,
   output logic [shift_unit_pkg::DATA_WIDTH-1:0]    o_product_high_half,
   output logic [shift_unit_pkg::DATA_WIDTH-1:0]    o_product_low_half,
   output logic                                     o_flag_write,
   output logic                                     o_shift_out_flag,
   output logic                                     o_shift_overflow_flag,
   output logic                                     o_precision_loss_flag
);
   import shift_unit_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_SHIFT} phase_t;

   typedef struct packed {
      phase_t                  phase;
      shift_kind_t             kind;
      logic                    use_reg_amount;
      logic                    byte_op;
      logic [CNT_WIDTH-1:0]    count;
      logic [WIDE_WIDTH-1:0]   work;
      logic                    out_bit;
      logic                    ovf;
      logic                    loss;
      logic [SEL_WIDTH-1:0]    amount_sel;
      logic [SEL_WIDTH-1:0]    target_sel;
      logic                    busy;
      logic                    done;
      logic                    write_alu;
      logic                    write_product;
      logic [DATA_WIDTH-1:0]   result;
      logic [DATA_WIDTH-1:0]   prod_hi;
      logic [DATA_WIDTH-1:0]   prod_lo;
      logic                    flag_write;
      logic                    flag_out;
      logic                    flag_ovf;
      logic                    flag_loss;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // One shift position of a 16-bit ALU value, with fill per signedness.
   function automatic logic [DATA_WIDTH-1:0] step16(input logic [DATA_WIDTH-1:0] v,
                                                    input shift_kind_t k);
      case (k)
         K_LEFT:         step16 = {v[DATA_WIDTH-2:0], 1'b0};                        // see RULE_16
         K_LEFT_SIGNED:  step16 = {v[DATA_WIDTH-1], v[DATA_WIDTH-3:0], 1'b0};       // see RULE_10
         K_RIGHT:        step16 = {1'b0, v[DATA_WIDTH-1:1]};                        // see RULE_16
         K_RIGHT_SIGNED: step16 = {v[DATA_WIDTH-1], v[DATA_WIDTH-1], v[DATA_WIDTH-2:1]}; // see RULE_10
         default:        step16 = v;
      endcase
   endfunction : step16

   // The bit that leaves the value on one shift position.
   function automatic logic lost_bit(input logic [WIDE_WIDTH-1:0] w, input shift_kind_t k);
      case (k)
         K_LEFT:        lost_bit = w[DATA_WIDTH-1];
         K_LEFT_SIGNED: lost_bit = w[DATA_WIDTH-2];
         default:       lost_bit = w[0];
      endcase
   endfunction : lost_bit

   // Decode, sequencing and flag tracking.
   always_comb begin
      logic [15:0] ins;
      logic        is_left;
      ins = i_instr;
      is_left = (state_reg.kind == K_LEFT) || (state_reg.kind == K_LEFT_SIGNED);
      state_next = state_reg;
      state_next.done = 1'b0;
      state_next.write_alu = 1'b0;
      state_next.write_product = 1'b0;
      state_next.flag_write = 1'b0;
      case (state_reg.phase)
         S_IDLE: begin
            if (i_instr_valid) begin
               state_next.out_bit = 1'b0;
               state_next.ovf = 1'b0;
               state_next.loss = 1'b0;
               state_next.use_reg_amount = 1'b0;
               state_next.byte_op = 1'b0;
               state_next.kind = K_NONE;
               state_next.amount_sel = ins[AMT_LSB +: SEL_WIDTH];           // see RULE_11
               state_next.target_sel = ins[TGT_LSB +: SEL_WIDTH];           // see RULE_11
               state_next.count = {12'h000, ins[IMM_LSB +: 4]};
               if (ins[15:6] == OP_PROD_RIGHT_REG && ins[2:0] == OP_PROD_TAIL) begin // see RULE_12
                  state_next.kind = K_PROD_RIGHT;
                  state_next.use_reg_amount = 1'b1;
               end else if (ins[15:7] == OP_PROD_RIGHT_IMM && ins[2:0] == OP_PROD_TAIL) begin // see RULE_12
                  state_next.kind = K_PROD_RIGHT;
               end else if (ins[15:3] == OP_LEFT_BYTE) begin                // see RULE_15
                  state_next.kind = K_LEFT;
                  state_next.byte_op = 1'b1;
                  state_next.count = CNT_WIDTH'(BYTE_SHIFT);
               end else if (ins[15:3] == OP_RIGHT_BYTE) begin               // see RULE_15
                  state_next.kind = K_RIGHT;
                  state_next.byte_op = 1'b1;
                  state_next.count = CNT_WIDTH'(BYTE_SHIFT);
               end else begin
                  state_next.use_reg_amount = 1'b1;
                  case (ins[15:6])                                           // see RULE_13
                     OP_LEFT_REG:         state_next.kind = K_LEFT;
                     OP_LEFT_SIGNED_REG:  state_next.kind = K_LEFT_SIGNED;
                     OP_RIGHT_REG:        state_next.kind = K_RIGHT;
                     OP_RIGHT_SIGNED_REG: state_next.kind = K_RIGHT_SIGNED;
                     default: begin
                        state_next.use_reg_amount = 1'b0;
                        case (ins[15:7])                                     // see RULE_14
                           OP_LEFT_IMM:        state_next.kind = K_LEFT;
                           OP_LEFT_SIGNED_IMM: state_next.kind = K_LEFT_SIGNED;
                           OP_RIGHT_IMM:       state_next.kind = K_RIGHT;
                           default:            state_next.kind = K_NONE;
                        endcase
                     end
                  endcase
               end
               if (state_next.kind != K_NONE) begin
                  state_next.phase = S_FETCH;
                  state_next.busy = 1'b1;
               end
            end
         end
         S_FETCH: begin
            // Operand selects have been out one cycle; latch values now.
            if (state_reg.kind == K_PROD_RIGHT) begin
               state_next.work = {i_product_high_half, i_product_low_half}; // see RULE_01
            end else begin
               state_next.work = {16'h0000, i_target_value};
            end
            if (state_reg.use_reg_amount) begin
               state_next.count = i_amount_value;                          // see RULE_02, RULE_06, RULE_07
            end
            if (state_reg.count == CNT_WIDTH'(BYTE_SHIFT) && !state_reg.use_reg_amount
                && state_reg.kind != K_PROD_RIGHT && state_reg.kind != K_LEFT_SIGNED
                && state_reg.kind != K_RIGHT_SIGNED && state_reg.byte_op) begin
               // Byte shift: eight positions in one cycle.              // see RULE_08
               state_next.work = (state_reg.kind == K_LEFT)
                  ? {16'h0000, i_target_value[7:0], 8'h00}
                  : {16'h0000, 8'h00, i_target_value[15:8]};
               state_next.out_bit = (state_reg.kind == K_LEFT) ? i_target_value[8]
                                                               : i_target_value[7];
               state_next.ovf = (state_reg.kind == K_LEFT) && (i_target_value[15:8] != 8'h00);
               state_next.loss = (state_reg.kind == K_RIGHT) && (i_target_value[7:0] != 8'h00);
               state_next.count = RESET_CNT;
            end
            state_next.phase = S_SHIFT;
         end
         S_SHIFT: begin
            if (state_reg.count != RESET_CNT) begin
               // One position per cycle.                                 // see RULE_02, RULE_03, RULE_09
               state_next.out_bit = lost_bit(state_reg.work, state_reg.kind);
               if (is_left) begin
                  state_next.ovf = state_reg.ovf | lost_bit(state_reg.work, state_reg.kind);
               end else begin
                  state_next.loss = state_reg.loss | state_reg.work[0];
               end
               if (state_reg.kind == K_PROD_RIGHT) begin
                  state_next.work = {1'b0, state_reg.work[WIDE_WIDTH-1:1]};  // see RULE_16
               end else begin
                  state_next.work = {16'h0000, step16(state_reg.work[DATA_WIDTH-1:0],
                                                       state_reg.kind)};
               end
               state_next.count = state_reg.count - 16'h0001;
            end else begin
               state_next.phase = S_IDLE;
               state_next.busy = 1'b0;
               state_next.done = 1'b1;
               state_next.flag_write = 1'b1;                                 // see RULE_04, RULE_05
               state_next.flag_out = state_reg.out_bit;
               state_next.flag_ovf = is_left ? state_reg.ovf : state_reg.flag_ovf;
               state_next.flag_loss = is_left ? state_reg.flag_loss : state_reg.loss;
               if (state_reg.kind == K_PROD_RIGHT) begin
                  state_next.write_product = 1'b1;
                  state_next.prod_hi = state_reg.work[WIDE_WIDTH-1:DATA_WIDTH];
                  state_next.prod_lo = state_reg.work[DATA_WIDTH-1:0];
               end else begin
                  state_next.write_alu = 1'b1;
                  state_next.result = state_reg.work[DATA_WIDTH-1:0];
               end
            end
         end
         default: begin
            state_next.phase = S_IDLE;
            state_next.busy = 1'b0;
         end
      endcase
   end

   // State registers.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_amount_sel = state_reg.amount_sel;
   assign o_target_sel = state_reg.target_sel;
   assign o_busy = state_reg.busy;
   assign o_done = state_reg.done;
   assign o_write_alu = state_reg.write_alu;
   assign o_write_product = state_reg.write_product;
   assign o_result = state_reg.result;
   assign o_product_high_half = state_reg.prod_hi;
   assign o_product_low_half = state_reg.prod_lo;
   assign o_flag_write = state_reg.flag_write;
   assign o_shift_out_flag = state_reg.flag_out;
   assign o_shift_overflow_flag = state_reg.flag_ovf;
   assign o_precision_loss_flag = state_reg.flag_loss;

   // Checks on timing, count steps, sign and zero fill, decode, flags and write-back behaviour.
   sequence s_start;
      state_reg.phase == S_IDLE && state_next.phase == S_FETCH;
   endsequence
   property p_byte_one_cycle;
      @(posedge i_clock) disable iff (!i_reset_n)
      (s_start ##0 state_next.byte_op) |-> ##3 o_done;
   endproperty
   a_byte_one_cycle: assert property (p_byte_one_cycle) else $error("byte shift slow"); // see RULE_08
   property p_signed_keeps_sign;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg.phase == S_SHIFT && state_reg.count != 16'h0000
       && (state_reg.kind == K_LEFT_SIGNED || state_reg.kind == K_RIGHT_SIGNED))
      |=> state_reg.work[15] == $past(state_reg.work[15]);
   endproperty
   a_signed_keeps_sign: assert property (p_signed_keeps_sign) else $error("sign bit changed"); // see RULE_10
   property p_count_steps;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg.phase == S_SHIFT && state_reg.count != 16'h0000)
      |=> state_reg.count == $past(state_reg.count) - 16'h0001;
   endproperty
   a_count_steps: assert property (p_count_steps) else $error("count not one per cycle"); // see RULE_02
   property p_imm_length;
      @(posedge i_clock) disable iff (!i_reset_n)
      (s_start ##0 (state_next.kind == K_LEFT && !state_next.use_reg_amount
       && !state_next.byte_op && i_instr[6:3] == 4'h3)) |-> ##6 o_done;
   endproperty
   a_imm_length: assert property (p_imm_length) else $error("imm shift wrong length"); // see RULE_09
   property p_flags_with_done;
      @(posedge i_clock) disable iff (!i_reset_n)
      o_done |-> o_flag_write && (o_write_alu || o_write_product);
   endproperty
   a_flags_with_done: assert property (p_flags_with_done) else $error("flags not written"); // see RULE_04
   property p_left_keeps_loss;
      @(posedge i_clock) disable iff (!i_reset_n)
      (o_done && o_write_alu && $past(state_reg.kind == K_LEFT))
      |-> $stable(o_precision_loss_flag);
   endproperty
   a_left_keeps_loss: assert property (p_left_keeps_loss) else $error("left touched loss"); // see RULE_05
   property p_prod_decode;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg.phase == S_IDLE && i_instr_valid && i_instr[15:6] == OP_PROD_RIGHT_REG
       && i_instr[2:0] == OP_PROD_TAIL) |=> state_reg.kind == K_PROD_RIGHT;
   endproperty
   a_prod_decode: assert property (p_prod_decode) else $error("product decode missed"); // see RULE_12
   property p_byte_decode;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg.phase == S_IDLE && i_instr_valid && i_instr[15:3] == OP_RIGHT_BYTE)
      |=> state_reg.kind == K_RIGHT && state_reg.byte_op;
   endproperty
   a_byte_decode: assert property (p_byte_decode) else $error("byte decode missed"); // see RULE_15
   property p_right_zero_fill;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg.phase == S_SHIFT && state_reg.count != 16'h0000 && state_reg.kind == K_RIGHT)
      |=> state_reg.work[15] == 1'b0;
   endproperty
   a_right_zero_fill: assert property (p_right_zero_fill) else $error("right fill not zero"); // see RULE_16
endmodule : microcore_shift_unit

// ===== tb/operand_file_model.sv
// Behavioural model of the ALU operand registers and the product pair.
// Assumes the shift unit reads operands combinationally through its selects
// and writes results back on its one-cycle write strobes.
`timescale 1ns/1ps
module operand_file_model (
   input  wire logic                                  i_clock,
   input  wire logic [shift_unit_pkg::SEL_WIDTH-1:0]  i_amount_sel,
   input  wire logic [shift_unit_pkg::SEL_WIDTH-1:0]  i_target_sel,
   input  wire logic                                  i_write_alu,
   input  wire logic                                  i_write_product,
   input  wire logic [shift_unit_pkg::DATA_WIDTH-1:0] i_result,
   input  wire logic [shift_unit_pkg::DATA_WIDTH-1:0] i_product_high_half,
   input  wire logic [shift_unit_pkg::DATA_WIDTH-1:0] i_product_low_half,
   output logic [shift_unit_pkg::DATA_WIDTH-1:0]      o_amount_value,
   output logic [shift_unit_pkg::DATA_WIDTH-1:0]      o_target_value,
   output logic [shift_unit_pkg::DATA_WIDTH-1:0]      o_product_high_half,
   output logic [shift_unit_pkg::DATA_WIDTH-1:0]      o_product_low_half
);
   import shift_unit_pkg::*;
   logic [DATA_WIDTH-1:0] regs [8];
   logic [WIDE_WIDTH-1:0] pair;
   // Registers start cleared so the unit never reads unknown operands.
   initial begin
      foreach (regs[i]) regs[i] = '0;
      pair = '0;
   end
   // Operand reads are selected by 3-bit fields of the instruction.
   assign o_amount_value = regs[i_amount_sel];
   assign o_target_value = regs[i_target_sel];
   // The pair is high half over low half.
   assign {o_product_high_half, o_product_low_half} = pair;
   // Results land on the edge that carries the write strobe.
   always @(posedge i_clock) begin
      if (i_write_alu) regs[i_target_sel] <= i_result;
      if (i_write_product) pair <= {i_product_high_half, i_product_low_half};
   end
endmodule : operand_file_model

// ===== tb/testbench.sv
// Self-checking testbench of the microcore shift unit.
// Assumes the operand model answers select lookups in the same cycle.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_total++; \
   $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module testbench;
   import shift_unit_pkg::*;
   logic                  i_clock, i_reset_n, i_instr_valid;
   logic [15:0]           i_instr;
   logic [DATA_WIDTH-1:0] amt_v, tgt_v, ph_i, pl_i, res, ph_o, pl_o;
   logic [SEL_WIDTH-1:0]  asel, tsel;
   logic                  busy, done, wr_alu, wr_prod, fwr, f_out, f_ovf, f_loss;
   int                    err_total, checked;

   microcore_shift_unit dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_amount_value(amt_v),
      .i_target_value(tgt_v), .i_product_high_half(ph_i), .i_product_low_half(pl_i),
      .o_amount_sel(asel), .o_target_sel(tsel), .o_busy(busy), .o_done(done),
      .o_write_alu(wr_alu), .o_write_product(wr_prod), .o_result(res),
      .o_product_high_half(ph_o), .o_product_low_half(pl_o), .o_flag_write(fwr),
      .o_shift_out_flag(f_out), .o_shift_overflow_flag(f_ovf),
      .o_precision_loss_flag(f_loss));
   operand_file_model model_u (.i_clock(i_clock), .i_amount_sel(asel),
      .i_target_sel(tsel), .i_write_alu(wr_alu), .i_write_product(wr_prod),
      .i_result(res), .i_product_high_half(ph_o), .i_product_low_half(pl_o),
      .o_amount_value(amt_v), .o_target_value(tgt_v), .o_product_high_half(ph_i),
      .o_product_low_half(pl_i));

   // Free-running 125 MHz clock.
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   // Prints the counts and the verdict, then stops.
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim

   // Works out result, shift-out bit and the overflow or loss flag of one op.
   function automatic void expect_op(input int op, input int n, input logic [15:0] v,
      input logic [31:0] p, output logic [15:0] r, output logic [31:0] pr,
      output logic so, output logic fl);
      r = v;
      pr = p;
      so = 1'b0;
      fl = 1'b0;
      case (op)
         0, 1: begin
            pr = p >> n;
            if (n > 0) so = p[n-1];
            fl = |(p & ((32'h1 << n) - 1));
         end
         2, 6, 9: begin
            r = v << n;
            if (n > 0) so = v[16-n];
            fl = |(({16'h0000, v} << n) >> 16);
         end
         3, 7: begin
            r = {v[15], v[14:0] << n};
            if (n > 0) so = v[15-n];
            fl = |(({17'h00000, v[14:0]} << n) >> 15);
         end
         default: begin
            if (op == 5) r = $signed(v) >>> n;
            else r = v >> n;
            if (n > 0) so = v[n-1];
            fl = |({16'h0000, v} & ((32'h1 << n) - 1));
         end
      endcase
   endfunction : expect_op

   // Loads operands, issues one shift and checks timing, result and flags.
   task automatic run_op(input int op, input int n, input logic [15:0] v, input bit poke);
      logic [2:0]  ts, as;
      logic [15:0] instr, er;
      logic [31:0] p, ep;
      logic        eso, efl;
      int          k;
      if (op >= 9) n = 8;
      ts = 3'($urandom);
      as = ts ^ 3'(1 + $urandom % 7);
      p = $urandom;
      model_u.regs[ts] = v;
      model_u.regs[as] = 16'(n);
      model_u.pair = p;
      case (op)
         0: instr = {OP_PROD_RIGHT_REG, as, OP_PROD_TAIL};
         1: instr = {OP_PROD_RIGHT_IMM, 4'(n), OP_PROD_TAIL};
         2: instr = {OP_LEFT_REG, as, ts};
         3: instr = {OP_LEFT_SIGNED_REG, as, ts};
         4: instr = {OP_RIGHT_REG, as, ts};
         5: instr = {OP_RIGHT_SIGNED_REG, as, ts};
         6: instr = {OP_LEFT_IMM, 4'(n), ts};
         7: instr = {OP_LEFT_SIGNED_IMM, 4'(n), ts};
         8: instr = {OP_RIGHT_IMM, 4'(n), ts};
         9: instr = {OP_LEFT_BYTE, ts};
         default: instr = {OP_RIGHT_BYTE, ts};
      endcase
      expect_op(op, n, v, p, er, ep, eso, efl);
      i_instr = instr;
      i_instr_valid = 1'b1;
      @(negedge i_clock);
      k = 0;
      while (done !== 1'b1 && k < 40) begin
         `CHK("busy_high", 1'b1, busy)
         // A second request while busy must be ignored.
         i_instr_valid = (poke && k == 1);
         i_instr = {OP_LEFT_BYTE, ts};
         @(negedge i_clock);
         k++;
      end
      i_instr_valid = 1'b0;
      `CHK("cycles", (op >= 9) ? 2 : n + 2, k)
      `CHK("busy", 1'b0, busy)
      `CHK("flag_write", 1'b1, fwr)
      `CHK("shift_out", eso, f_out)
      if (op < 2) begin
         `CHK("write_product", 1'b1, wr_prod)
         `CHK("product", ep, {ph_o, pl_o})
      end else begin
         `CHK("write_alu", 1'b1, wr_alu)
         `CHK("result", er, res)
      end
      if (op == 2 || op == 3 || op == 6 || op == 7 || op == 9) `CHK("overflow", efl, f_ovf)
      if (op < 2 || op == 4 || op == 5 || op == 8 || op == 10) `CHK("loss", efl, f_loss)
      @(negedge i_clock);
      `CHK("done_pulse", 1'b0, done)
      if (poke) begin
         repeat (6) begin
            @(negedge i_clock);
            `CHK("no_second_done", 1'b0, done)
         end
      end
   endtask : run_op

   // Main sequence: corners per op, random ops, refused requests, bad opcodes.
   initial begin
      logic [15:0] pat [3];
      int          n;
      pat = '{16'h8001, 16'hFFFF, 16'h4AC3};
      void'($urandom(53312));
      i_reset_n = 1'b0;
      i_instr_valid = 1'b0;
      i_instr = 16'h0000;
      repeat (6) @(negedge i_clock);
      i_reset_n = 1'b1;
      @(negedge i_clock);
      for (int op = 0; op < 11; op++) begin
         for (int j = 0; j < 4; j++) begin
            n = (j == 0) ? 0 : (j == 1) ? 1 : (j == 2) ? 15 : $urandom % 16;
            if (op >= 9) n = 8;
            run_op(op, n, (j < 3) ? pat[j] : 16'($urandom), 1'b0);
         end
      end
      $display("Test corner shifts finished");
      repeat (60) run_op($urandom % 11, $urandom % 16, 16'($urandom), 1'b0);
      $display("Test random shifts finished");
      run_op(2, 5, 16'h1357, 1'b1);
      run_op(0, 9, 16'h0000, 1'b1);
      run_op(6, 3, 16'h9E37, 1'b1);
      $display("Test busy refusal finished");
      foreach (pat[i]) begin
         i_instr = (i == 0) ? 16'hFFFF : {OP_PROD_RIGHT_REG, 3'h2, 3'h4};
         i_instr_valid = 1'b1;
         @(negedge i_clock);
         i_instr_valid = 1'b0;
         repeat (20) begin
            @(negedge i_clock);
            `CHK("unknown_opcode_done", 1'b0, done)
            `CHK("unknown_opcode_busy", 1'b0, busy)
         end
      end
      $display("Test unknown opcodes finished");
      end_sim;
   end

   // Watchdog well beyond the expected run length.
   initial begin
      #(8 * 20000);
      err_total++;
      $display("BAD watchdog expected %h seen %h", 1'b0, 1'b1);
      end_sim;
   end
endmodule : testbench
